// ---- rtl/lpsd_mem.sv ----
// SDRAM device end: two banks, 1M x 32 words, burst access and power modes.
// Assumes every pin comes from logic on the same clock, so nothing is synchronised;
// the clock-enable pin acts as the gate that freezes this end.
//
// The register addresses and strobed register access were left to the implementer.
`default_nettype none
module lpsd_mem (
  input wire logic clock,
  input wire logic rst,
  lpsd_link_if.mem lk
);
  import lpsd_pkg::*;

  typedef enum logic [1:0] {
    LPSD_PW_RUN,
    LPSD_PW_SUSP,
    LPSD_PW_PDN,
    LPSD_PW_SREF
  } lpsd_pw_e;

  typedef struct packed {
    logic act;
    logic wr;
    logic bank;
    logic [LPSD_COL_W-1:0] start;
    logic [8:0] cnt;
    logic [8:0] len;
    logic page;
    logic ap;
  } lpsd_burst_s;

  typedef struct packed {
    lpsd_pw_e pw;
    logic [LPSD_MODE_W-1:0] mode;
    logic [1:0] open;
    logic [1:0][LPSD_ROW_W-1:0] row;
    lpsd_burst_s b;
    logic [LPSD_LANES-1:0] dqm_d1;
    logic [LPSD_LANES-1:0] dqm_d2;
    logic [LPSD_PIPE-1:0] pipe_v;
    logic [LPSD_PIPE-1:0][LPSD_DQ_W-1:0] pipe_d;
  } lpsd_mem_s;

  lpsd_mem_s s;
  lpsd_mem_s next_s;

  // One word per bank, row and column
  logic [LPSD_DQ_W-1:0] array_q [0:(1 << LPSD_WORD_AW)-1];

  lpsd_cmd_e cmd;
  logic go;
  logic start;
  logic beat;
  logic wr_en;
  lpsd_burst_s bb;
  logic [LPSD_COL_W-1:0] col;
  logic [LPSD_COL_W-1:0] blk;
  logic [LPSD_WORD_AW-1:0] waddr;
  logic [LPSD_DQ_W-1:0] wr_word;
  logic [1:0] cl;

  assign cmd = lpsd_cmd_e'({lk.ras_n, lk.cas_n, lk.we_n});
  assign cl = s.mode[LPSD_MODE_CL_LSB +: 2];

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_s = s;
    go = 1'b0;
    unique case (s.pw)
      LPSD_PW_RUN: begin
        if (!lk.cke) begin
          // Gate the clock; which low-power state depends on what is busy
          if (s.b.act) begin
            next_s.pw = LPSD_PW_SUSP;
          end else if (!lk.cs_n && cmd == LPSD_CMD_REF) begin
            next_s.pw = LPSD_PW_SREF;
          end else begin
            next_s.pw = LPSD_PW_PDN;
          end
        end else begin
          go = 1'b1;
        end
      end
      LPSD_PW_SUSP: begin
        // Burst and outputs hold; resume on the next enabled edge
        if (lk.cke) begin
          next_s.pw = LPSD_PW_RUN;
        end
      end
      LPSD_PW_PDN, LPSD_PW_SREF: begin
        // Only the raw enable level is looked at, every other input is ignored
        if (lk.cke) begin
          next_s.pw = LPSD_PW_RUN;
        end
      end
    endcase

    // New burst from a read or write command, else the running one
    start = go && !lk.cs_n && (cmd == LPSD_CMD_RD || cmd == LPSD_CMD_WR);
    bb = s.b;
    if (start) begin
      bb.act = 1'b1;
      bb.wr = (cmd == LPSD_CMD_WR);
      bb.bank = lk.bank_select;
      bb.start = lk.address_inputs[LPSD_COL_W-1:0];
      bb.ap = lk.address_inputs[LPSD_AP_BIT];
      bb.cnt = 9'h000;
      bb.len = lpsd_burst_len(s.mode[LPSD_MODE_BL_LSB +: 3]);
      if (bb.wr && s.mode[LPSD_MODE_WB]) begin
        bb.len = 9'h001;
      end
      bb.page = (bb.len == LPSD_PAGE_LEN);
    end
    beat = go && bb.act;

    // Block wrap: sequential adds, interleaved xors within the block
    blk = bb.len[LPSD_COL_W-1:0] - 8'h01;
    if (s.mode[LPSD_MODE_BT] && !bb.page) begin
      col = (bb.start & ~blk) | ((bb.start ^ bb.cnt[LPSD_COL_W-1:0]) & blk);
    end else begin
      col = (bb.start & ~blk) | ((bb.start + bb.cnt[LPSD_COL_W-1:0]) & blk);
    end
    waddr = {bb.bank, s.row[bb.bank], col};
    wr_en = beat && bb.wr;

    if (go) begin
      // Output side moves on every enabled edge
      next_s.dqm_d1 = lk.byte_mask;
      next_s.dqm_d2 = s.dqm_d1;
      next_s.pipe_v = {s.pipe_v[LPSD_PIPE-2:0], 1'b0};
      next_s.pipe_d = {s.pipe_d[LPSD_PIPE-2:0], {LPSD_DQ_W{1'b0}}};
      if (!lk.cs_n) begin
        unique case (cmd)
          LPSD_CMD_LMR: next_s.mode = {lk.bank_select, lk.address_inputs};
          LPSD_CMD_ACT: begin
            next_s.open[lk.bank_select] = 1'b1;
            next_s.row[lk.bank_select] = lk.address_inputs;
          end
          LPSD_CMD_PRE: begin
            if (lk.address_inputs[LPSD_AP_BIT]) begin
              next_s.open = 2'h0;
            end else begin
              next_s.open[lk.bank_select] = 1'b0;
            end
          end
          default: begin
          end
        endcase
      end
      next_s.b = bb;
      if (beat) begin
        // Read data enters so that it leaves the last stage after the latency
        if (!bb.wr && cl != 2'h0) begin
          next_s.pipe_v[LPSD_PIPE - 32'(cl)] = 1'b1;
          next_s.pipe_d[LPSD_PIPE - 32'(cl)] = array_q[waddr];
        end
        next_s.b.cnt = bb.cnt + 9'h001;
        // A page burst wraps until terminated
        if (!bb.page && bb.cnt + 9'h001 == bb.len) begin
          next_s.b.act = 1'b0;
          if (bb.ap) begin
            next_s.open[bb.bank] = 1'b0;
          end
        end
      end
      if (!lk.cs_n && cmd == LPSD_CMD_BST) begin
        next_s.b.act = 1'b0;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s <= '{pw: LPSD_PW_RUN, mode: LPSD_MODE_RST, open: 2'h0, row: '0, b: '0,
             dqm_d1: '0, dqm_d2: '0, pipe_v: '0, pipe_d: '0};
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------
  // Byte lanes
  // ----------------------------------------
  for (genvar g = 0; g < LPSD_LANES; g++) begin : g_lane
    // Masked lanes keep their old byte so that one process owns the whole array
    assign wr_word[8*g +: 8] = lk.byte_mask[g] ? array_q[waddr][8*g +: 8] :
                               lk.dq[8*g +: 8];
    // Drive only while read data stands and its mask was low two edges ago
    assign lk.dq_mem_oe_n[g] = !(s.pipe_v[LPSD_PIPE-1] && !s.dqm_d2[g]);
  end

  // Write data rides with the command and each following beat
  always_ff @(posedge clock) begin
    if (wr_en) begin
      array_q[waddr] <= wr_word;
    end
  end

  assign lk.dq_mem = s.pipe_d[LPSD_PIPE-1];
endmodule
`default_nettype wire

// ---- rtl/lpsd_pkg.sv ----
// Shared constants and types for the low-power SDRAM pin link.
// Assumes one 125 MHz clock shared by the controller and the memory model.
`default_nettype none
package lpsd_pkg;
  // ----------------------------------------
  // Geometry
  // ----------------------------------------
  localparam int LPSD_DQ_W = 32;
  localparam int LPSD_LANES = 4;
  localparam int LPSD_ROW_W = 11;
  localparam int LPSD_COL_W = 8;
  localparam int LPSD_ADDR_W = 11;
  localparam int LPSD_WORD_AW = 20;
  localparam int LPSD_AP_BIT = 10;
  localparam int LPSD_PIPE = 3;
  localparam logic [8:0] LPSD_PAGE_LEN = 9'h100;
  // ----------------------------------------
  // Mode word layout, {bank_select, address_inputs}
  // ----------------------------------------
  localparam int LPSD_MODE_W = 12;
  localparam int LPSD_MODE_BL_LSB = 0;
  localparam int LPSD_MODE_BT = 3;
  localparam int LPSD_MODE_CL_LSB = 4;
  localparam int LPSD_MODE_WB = 9;
  localparam logic [2:0] LPSD_BL_PAGE = 3'h7;
  localparam logic [11:0] LPSD_MODE_RST = 12'h020;
  localparam logic [1:0] LPSD_CL_RST = 2'h2;
  // ----------------------------------------
  // Command codes on {ras_n, cas_n, we_n} with cs_n low
  // ----------------------------------------
  typedef enum logic [2:0] {
    LPSD_CMD_LMR = 3'h0,
    LPSD_CMD_REF = 3'h1,
    LPSD_CMD_PRE = 3'h2,
    LPSD_CMD_ACT = 3'h3,
    LPSD_CMD_WR = 3'h4,
    LPSD_CMD_RD = 3'h5,
    LPSD_CMD_BST = 3'h6,
    LPSD_CMD_NOP = 3'h7
  } lpsd_cmd_e;
  // ----------------------------------------
  // Start-up wait of the controller
  // ----------------------------------------
  localparam int LPSD_CLK_MHZ = 125;
  localparam int LPSD_INIT_US = 100;
  localparam int LPSD_INIT_CYCLES = LPSD_INIT_US * LPSD_CLK_MHZ;
  localparam int LPSD_INIT_CNT_W = 14;

  function automatic logic [8:0] lpsd_burst_len(input logic [2:0] code);
    logic [8:0] len;
    len = 9'h001;
    unique case (code)
      3'h1: len = 9'h002;
      3'h2: len = 9'h004;
      3'h3: len = 9'h008;
      LPSD_BL_PAGE: len = LPSD_PAGE_LEN;
      default: len = 9'h001;
    endcase
    return len;
  endfunction
endpackage
`default_nettype wire

// ---- rtl/lpsd_link_if.sv ----
// Pin bundle between the SDRAM controller and the SDRAM device.
// Assumes both ends share one clock; the data bus is resolved here per byte lane.
`default_nettype none
interface lpsd_link_if;
  import lpsd_pkg::*;
  logic cke;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic bank_select;
  logic [LPSD_ADDR_W-1:0] address_inputs;
  logic [LPSD_LANES-1:0] byte_mask;
  logic [LPSD_DQ_W-1:0] dq_ctl;
  logic dq_ctl_oe_n;
  logic [LPSD_DQ_W-1:0] dq_mem;
  logic [LPSD_LANES-1:0] dq_mem_oe_n;
  logic [LPSD_DQ_W-1:0] dq;

  // ----------------------------------------
  // Bus resolution; an undriven lane reads zero
  // ----------------------------------------
  for (genvar g = 0; g < LPSD_LANES; g++) begin : g_lane
    assign dq[8*g +: 8] = !dq_mem_oe_n[g] ? dq_mem[8*g +: 8] :
                          (!dq_ctl_oe_n ? dq_ctl[8*g +: 8] : 8'h00);
  end

  modport ctl (
    output cke, cs_n, ras_n, cas_n, we_n, bank_select, address_inputs, byte_mask,
    output dq_ctl, dq_ctl_oe_n,
    input dq
  );
  modport mem (
    input cke, cs_n, ras_n, cas_n, we_n, bank_select, address_inputs, byte_mask,
    output dq_mem, dq_mem_oe_n,
    input dq
  );
endinterface
`default_nettype wire

// ---- rtl/lpsd_ctl.sv ----
// SDRAM controller end: registers user commands onto the pins.
// Assumes the user sequences commands and timing; this end adds the start-up
// wait and collects read bursts.
`default_nettype none
module lpsd_ctl #(
  parameter int unsigned INIT_WAIT = lpsd_pkg::LPSD_INIT_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  lpsd_link_if.ctl lk,
  input wire logic cmd_valid,
  input wire lpsd_pkg::lpsd_cmd_e cmd,
  input wire logic cmd_bank,
  input wire logic [lpsd_pkg::LPSD_ADDR_W-1:0] cmd_addr,
  input wire logic [lpsd_pkg::LPSD_DQ_W-1:0] wdata,
  input wire logic wdrive,
  input wire logic [lpsd_pkg::LPSD_LANES-1:0] wmask,
  input wire logic cke_on,
  output logic ready,
  output logic [lpsd_pkg::LPSD_DQ_W-1:0] rdata,
  output logic rvalid
);
  import lpsd_pkg::*;

  typedef enum logic {LPSD_ST_INIT, LPSD_ST_RUN} lpsd_st_e;
  typedef struct packed {
    lpsd_st_e st;
    logic [LPSD_INIT_CNT_W-1:0] wait_cnt;
    logic cke;
    logic cke_prev;
    logic cs_n;
    lpsd_cmd_e cmd;
    logic bank;
    logic [LPSD_ADDR_W-1:0] addr;
    logic [LPSD_LANES-1:0] mask;
    logic [LPSD_DQ_W-1:0] wd;
    logic wd_oe_n;
    logic [1:0] cl;
    logic [2:0] bl;
    logic wb;
    logic [1:0] rd_wait;
    logic [8:0] rd_left;
    logic [LPSD_DQ_W-1:0] rdata;
    logic rvalid;
  } lpsd_ctl_s;

  lpsd_ctl_s s;
  lpsd_ctl_s next_s;

  assign ready = (s.st == LPSD_ST_RUN);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_s = s;
    next_s.rvalid = 1'b0;
    next_s.cke_prev = s.cke;
    unique case (s.st)
      LPSD_ST_INIT: begin
        // Only NOP stays on the pins until the wait has run out
        next_s.cs_n = 1'b0;
        next_s.cmd = LPSD_CMD_NOP;
        next_s.wait_cnt = s.wait_cnt + 14'h0001;
        if (32'(s.wait_cnt) >= INIT_WAIT - 1) begin
          next_s.st = LPSD_ST_RUN;
        end
      end
      LPSD_ST_RUN: begin
        // Power-down only when the user asks; otherwise clock enable stays high
        next_s.cke = cke_on;
        next_s.cs_n = !cmd_valid;
        next_s.cmd = cmd_valid ? cmd : LPSD_CMD_NOP;
        next_s.bank = cmd_bank;
        next_s.addr = cmd_addr;
        next_s.mask = wmask;
        next_s.wd = wdata;
        next_s.wd_oe_n = !wdrive;
        if (cmd_valid && cmd == LPSD_CMD_LMR) begin
          next_s.cl = cmd_addr[LPSD_MODE_CL_LSB +: 2];
          next_s.bl = cmd_addr[LPSD_MODE_BL_LSB +: 3];
          next_s.wb = cmd_addr[LPSD_MODE_WB];
        end
      end
    endcase
    // The device also loses its wake-up edge, so collection needs two high samples
    if (s.cke && s.cke_prev) begin
      if (s.rd_wait != 2'h0) begin
        next_s.rd_wait = s.rd_wait - 2'h1;
      end else if (s.rd_left != 9'h000) begin
        next_s.rd_left = s.rd_left - 9'h001;
        next_s.rdata = lk.dq;
        next_s.rvalid = 1'b1;
      end
    end
    // A command that the device drops while asleep or waking starts nothing here
    if (s.st == LPSD_ST_RUN && cmd_valid && cke_on && s.cke) begin
      if (cmd == LPSD_CMD_RD) begin
        next_s.rd_wait = cmd_valid ? s.cl : 2'h0;
        next_s.rd_left = lpsd_burst_len(s.bl);
      end else if (cmd == LPSD_CMD_BST || cmd == LPSD_CMD_WR) begin
        next_s.rd_left = 9'h000;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s <= '{st: LPSD_ST_INIT, wait_cnt: '0, cke: 1'b1, cs_n: 1'b1, cmd: LPSD_CMD_NOP,
             bank: 1'b0, addr: '0, mask: '0, wd: '0, wd_oe_n: 1'b1, cl: LPSD_CL_RST,
             bl: 3'h0, wb: 1'b0, rd_wait: 2'h0, rd_left: 9'h000, rdata: '0,
             rvalid: 1'b0, cke_prev: 1'b1};
    end else if (ce) begin
      s <= next_s;
    end
  end

  // ----------------------------------------
  // Pins
  // ----------------------------------------
  assign lk.cke = s.cke;
  assign lk.cs_n = s.cs_n;
  assign {lk.ras_n, lk.cas_n, lk.we_n} = s.cmd;
  assign lk.bank_select = s.bank;
  assign lk.address_inputs = s.addr;
  assign lk.byte_mask = s.mask;
  assign lk.dq_ctl = s.wd;
  assign lk.dq_ctl_oe_n = s.wd_oe_n;
  assign rdata = s.rdata;
  assign rvalid = s.rvalid;
endmodule
`default_nettype wire

// ---- testbench/lpsd_link_monitor.sv ----
// Concurrent checks on the controller-to-memory pin link.
// Assumes CAS latency 2 and a testbench that wires in the link signals.
`default_nettype none
module lpsd_link_monitor (
  input wire logic clock,
  input wire logic rst,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [lpsd_pkg::LPSD_LANES-1:0] byte_mask,
  input wire logic dq_ctl_oe_n,
  input wire logic [lpsd_pkg::LPSD_LANES-1:0] dq_mem_oe_n
);
  timeunit 1ns;
  timeprecision 100ps;
  import lpsd_pkg::*;
  // --------
  // Helper state
  // --------
  typedef struct packed {logic cke_q; logic rd_q1; logic rd_q2;} lpsd_mon_s;
  lpsd_mon_s st;
  lpsd_mon_s next_st;
  logic rd_now;
  // A read taken on the power-down exit edge does not count
  assign rd_now = cke && st.cke_q && !cs_n && ras_n && !cas_n && we_n;
  always_comb begin
    next_st = st;
    next_st.cke_q = cke;
    next_st.rd_q1 = rd_now;
    next_st.rd_q2 = st.rd_q1;
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st <= '{cke_q: 1'b1, rd_q1: 1'b0, rd_q2: 1'b0};
    end else begin
      st <= next_st;
    end
  end
  default clocking mon_cb @(posedge clock);
  endclocking
  default disable iff (rst);
  // --------
  // Properties
  // --------
  a_one_driver: assert property (!dq_ctl_oe_n |-> dq_mem_oe_n == 4'hf)
    else $error("both ends drive the data bus");
  a_mask_floats: assert property ((~dq_mem_oe_n & $past(byte_mask, 2)) == 4'h0)
    else $error("masked lane driven during read");
  a_read_starts: assert property ((dq_mem_oe_n != 4'hf)
    && ($past(dq_mem_oe_n) == 4'hf) |-> st.rd_q2)
    else $error("device drives without a selected read");
  a_read_latency: assert property (rd_now && byte_mask == 4'h0
    && $past(byte_mask) == 4'h0 ##1 cke |-> ##1 dq_mem_oe_n == 4'h0)
    else $error("read data not driven two edges after read");
  a_pdn_quiet: assert property (!cke && !st.cke_q
    && $past(dq_mem_oe_n) == 4'hf |-> dq_mem_oe_n == 4'hf)
    else $error("device drives while asleep");
  a_exit_ignored: assert property (cke && !st.cke_q && !cs_n
    && ras_n && !cas_n && we_n && dq_mem_oe_n == 4'hf
    |-> ##1 dq_mem_oe_n == 4'hf ##1 dq_mem_oe_n == 4'hf)
    else $error("read accepted on wake-up edge");
  a_reset_float: assert property ($fell(rst) |-> dq_mem_oe_n == 4'hf && dq_ctl_oe_n)
    else $error("data bus driven after reset");
  a_init_nop: assert property ($fell(rst) |-> (cs_n || (ras_n && cas_n && we_n)) [*6])
    else $error("command issued during start-up wait");
endmodule
`default_nettype wire

// ---- testbench/tb_lp_sdram_pin_interface.sv ----
// Testbench joining the SDRAM controller and memory ends over the pin link.
// Assumes one 125 MHz clock and a shortened start-up wait of 8 cycles.
`default_nettype none
`define CHECK_EQ(got, exp) \
  begin \
    checked++; \
    if ((got) !== (exp)) begin \
      bad_count++; \
      $display("[FAIL] %0t got %h expected %h", $time, (got), (exp)); \
    end \
  end
module tb_lp_sdram_pin_interface;
  timeunit 1ns;
  timeprecision 100ps;
  import lpsd_pkg::*;
  typedef struct packed {
    logic bank; logic [10:0] row; logic [7:0] col;
    logic [31:0] a; logic [31:0] b; logic [3:0] wm; logic [3:0] rm; logic v;
  } lpsd_row_s;
  // Second write uses mask wm (or is deselected when v is low); read uses mask rm
  localparam lpsd_row_s ROWS [5] = '{
    '{1'h0, 11'h000, 8'h00, 32'h1111_1111, 32'hA5A5_0F0F, 4'h0, 4'h0, 1'h1},
    '{1'h1, 11'h7FF, 8'hFF, 32'h0123_4567, 32'hFEDC_BA98, 4'h5, 4'h0, 1'h1},
    '{1'h0, 11'h400, 8'h80, 32'h3C3C_3C3C, 32'hC3C3_C3C3, 4'hA, 4'h1, 1'h1},
    '{1'h1, 11'h155, 8'h2A, 32'h7E7E_8181, 32'h0000_0000, 4'h0, 4'h8, 1'h0},
    '{1'h0, 11'h2AA, 8'h55, 32'h89AB_CDEF, 32'h1234_5678, 4'hF, 4'h6, 1'h1}};
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic cmd_valid = 1'b0;
  lpsd_cmd_e cmd = LPSD_CMD_NOP;
  logic cmd_bank = 1'b0;
  logic [10:0] cmd_addr = 11'h000;
  logic [31:0] wdata = 32'h0000_0000;
  logic wdrive = 1'b0;
  logic [3:0] wmask = 4'h0;
  logic cke_on = 1'b1;
  logic ready;
  logic [31:0] rdata;
  logic rvalid;
  int checked = 0;
  int bad_count = 0;
  int cycles = 0;
  // --------
  // Ends and checker
  // --------
  lpsd_link_if lpsd_link_if_inst();
  lpsd_ctl #(.INIT_WAIT(8)) lpsd_ctl_inst (.clock(clock), .rst(rst), .ce(ce),
    .lk(lpsd_link_if_inst), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_bank(cmd_bank),
    .cmd_addr(cmd_addr), .wdata(wdata), .wdrive(wdrive), .wmask(wmask), .cke_on(cke_on),
    .ready(ready), .rdata(rdata), .rvalid(rvalid));
  lpsd_mem lpsd_mem_inst (.clock(clock), .rst(rst), .lk(lpsd_link_if_inst));
  lpsd_link_monitor lpsd_link_monitor_inst (.clock(clock), .rst(rst),
    .cke(lpsd_link_if_inst.cke), .cs_n(lpsd_link_if_inst.cs_n),
    .ras_n(lpsd_link_if_inst.ras_n), .cas_n(lpsd_link_if_inst.cas_n),
    .we_n(lpsd_link_if_inst.we_n), .byte_mask(lpsd_link_if_inst.byte_mask),
    .dq_ctl_oe_n(lpsd_link_if_inst.dq_ctl_oe_n),
    .dq_mem_oe_n(lpsd_link_if_inst.dq_mem_oe_n));
  initial begin
    forever #4 clock = ~clock;
  end
  // --------
  // Tasks
  // --------
  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // One user cycle; entered just after a rising edge
  task automatic issue(input lpsd_cmd_e c, input logic b, input logic [10:0] a,
    input logic [31:0] d, input logic drv, input logic [3:0] m, input logic v);
    cmd_valid <= v;
    cmd <= c;
    cmd_bank <= b;
    cmd_addr <= a;
    wdata <= d;
    wdrive <= drv;
    wmask <= m;
    @(posedge clock);
  endtask
  // Mask leads the read by one cycle because it acts two edges ahead of the data
  task automatic rd(input logic b, input logic [7:0] col, input logic [3:0] m,
    output logic [31:0] w);
    int n;
    n = 0;
    issue(LPSD_CMD_NOP, b, 11'h000, 32'h0000_0000, 1'b0, m, 1'b1);
    issue(LPSD_CMD_RD, b, {3'h0, col}, 32'h0000_0000, 1'b0, m, 1'b1);
    issue(LPSD_CMD_NOP, b, 11'h000, 32'h0000_0000, 1'b0, 4'h0, 1'b1);
    while (rvalid !== 1'b1 && n < 10) begin
      @(posedge clock);
      n++;
    end
    w = rdata;
  endtask
  function automatic logic [31:0] expect_word(input lpsd_row_s r);
    logic [31:0] w;
    for (int g = 0; g < 4; g++) begin
      w[8*g +: 8] = r.rm[g] ? 8'h00 : ((r.v && !r.wm[g]) ? r.b[8*g +: 8] : r.a[8*g +: 8]);
    end
    return w;
  endfunction
  task automatic run_row(input lpsd_row_s r);
    logic [31:0] got;
    issue(LPSD_CMD_ACT, r.bank, r.row, 32'h0000_0000, 1'b0, 4'h0, 1'b1);
    issue(LPSD_CMD_WR, r.bank, {3'h0, r.col}, r.a, 1'b1, 4'h0, 1'b1);
    issue(LPSD_CMD_WR, r.bank, {3'h0, r.col}, r.b, 1'b1, r.wm, r.v);
    rd(r.bank, r.col, r.rm, got);
    `CHECK_EQ(got, expect_word(r));
    issue(LPSD_CMD_PRE, r.bank, 11'h400, 32'h0000_0000, 1'b0, 4'h0, 1'b1);
  endtask
  task automatic do_reset(input int hold);
    int n;
    n = 0;
    rst <= 1'b1;
    repeat (hold) @(posedge clock);
    rst <= 1'b0;
    repeat (4) @(posedge clock);
    `CHECK_EQ(ready, 1'b0);
    while (ready !== 1'b1 && n < 20) begin
      @(posedge clock);
      n++;
    end
    `CHECK_EQ(n < 10, 1'b1);
  endtask
  // --------
  // Sequence
  // --------
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      $display("[FAIL] %0t run did not complete", $time);
      tally_and_finish;
    end
  end
  initial begin
    logic [31:0] got;
    logic any;
    do_reset(8);
    foreach (ROWS[i]) begin
      run_row(ROWS[i]);
    end
    // Two-beat bursts, sequential: start at column 5 wraps back to 4
    issue(LPSD_CMD_LMR, 1'b0, 11'h021, 32'h0000_0000, 1'b0, 4'h0, 1'b1);
    issue(LPSD_CMD_ACT, 1'b0, 11'h003, 32'h0000_0000, 1'b0, 4'h0, 1'b1);
    issue(LPSD_CMD_WR, 1'b0, 11'h004, 32'hCAFE_0004, 1'b1, 4'h0, 1'b1);
    issue(LPSD_CMD_NOP, 1'b0, 11'h000, 32'hCAFE_0005, 1'b1, 4'h0, 1'b1);
    rd(1'b0, 8'h05, 4'h0, got);
    `CHECK_EQ(got, 32'hCAFE_0005);
    @(posedge clock);
    `CHECK_EQ(rvalid, 1'b1);
    `CHECK_EQ(rdata, 32'hCAFE_0004);
    // Four-beat interleaved bursts: a read from column 6 runs 6, 7, 4, 5
    issue(LPSD_CMD_LMR, 1'b0, 11'h02A, 32'h0000_0000, 1'b0, 4'h0, 1'b1);
    issue(LPSD_CMD_WR, 1'b0, 11'h004, 32'hCAFE_0004, 1'b1, 4'h0, 1'b1);
    issue(LPSD_CMD_NOP, 1'b0, 11'h000, 32'hCAFE_0005, 1'b1, 4'h0, 1'b1);
    issue(LPSD_CMD_NOP, 1'b0, 11'h000, 32'hCAFE_0006, 1'b1, 4'h0, 1'b1);
    issue(LPSD_CMD_NOP, 1'b0, 11'h000, 32'hCAFE_0007, 1'b1, 4'h0, 1'b1);
    rd(1'b0, 8'h06, 4'h0, got);
    `CHECK_EQ(got, 32'hCAFE_0006);
    @(posedge clock);
    `CHECK_EQ(rdata, 32'hCAFE_0007);
    @(posedge clock);
    `CHECK_EQ(rdata, 32'hCAFE_0004);
    @(posedge clock);
    `CHECK_EQ(rdata, 32'hCAFE_0005);
    // Power-down, then self refresh; reads while asleep or on wake-up are dropped
    for (int k = 0; k < 2; k++) begin
      any = 1'b0;
      cke_on <= 1'b0;
      issue(k == 0 ? LPSD_CMD_NOP : LPSD_CMD_REF, 1'b0, 11'h000, 32'h0000_0000, 1'b0,
        4'h0, 1'b1);
      issue(LPSD_CMD_RD, 1'b0, 11'h004, 32'h0000_0000, 1'b0, 4'h0, 1'b1);
      cke_on <= 1'b1;
      issue(LPSD_CMD_RD, 1'b0, 11'h005, 32'h0000_0000, 1'b0, 4'h0, 1'b1);
      issue(LPSD_CMD_NOP, 1'b0, 11'h000, 32'h0000_0000, 1'b0, 4'h0, 1'b1);
      repeat (8) begin
        @(posedge clock);
        any = any | rvalid;
      end
      `CHECK_EQ(any, 1'b0);
      rd(1'b0, 8'h04, 4'h0, got);
      `CHECK_EQ(got, 32'hCAFE_0004);
      repeat (2) @(posedge clock);
    end
    // Reset in mid-run brings the burst length back to one word
    do_reset(2);
    run_row(ROWS[0]);
    `CHECK_EQ(rvalid, 1'b0);
    tally_and_finish;
  end
endmodule
`undef CHECK_EQ
`default_nettype wire
